// ==== tmi_pkg.sv ====
// shared constants and types of the terminal mode interpreter
package tmi_pkg;

    // character layout: column bits above row bits
    localparam int CODE_W = 7;
    localparam int COL_W  = 3;
    localparam int ROW_W  = 4;
    localparam int COL_LO = ROW_W;
    localparam int COL_HI = CODE_W - 1;

    // highest column that still holds control codes
    localparam logic [COL_W-1:0] COL_CTRL_MAX = 3'h1;

    // codes with a meaning in escape sequences
    localparam logic [CODE_W-1:0] ESC_CODE = 7'h1b;
    localparam logic [CODE_W-1:0] KEY_F    = 7'h46;
    localparam logic [CODE_W-1:0] KEY_G    = 7'h47;
    localparam logic [CODE_W-1:0] KEY_ONE  = 7'h31;
    localparam logic [CODE_W-1:0] KEY_TWO  = 7'h32;

    // printable codes that select a special symbol in graphic mode
    localparam logic [CODE_W-1:0] SYM_FIRST = 7'h61;
    localparam logic [CODE_W-1:0] SYM_LAST  = 7'h7e;
    localparam int                SYM_COUNT = 30;
    localparam int                SYM_W     = 5;

    // input buffer
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        MODE_ALPHA   = 4'b0001,
        MODE_GRAPHIC = 4'b0010,
        MODE_DRAW    = 4'b0100,
        MODE_ESC     = 4'b1000
    } tmi_mode_t;

    typedef enum logic [2:0] {
        KIND_TEXT   = 3'h0,
        KIND_SYMBOL = 3'h1,
        KIND_GRAPH  = 3'h2,
        KIND_CTRL   = 3'h3,
        KIND_ESCFN  = 3'h4
    } tmi_kind_t;

    typedef struct packed {
        tmi_kind_t          kind;
        logic [CODE_W-1:0]  code;
        logic [SYM_W-1:0]   symbol;
        tmi_mode_t          mode;
    } tmi_event_t;

endpackage

// ==== tmi_interpreter.sv ====
// terminal mode interpreter with its input buffer
`timescale 1ns/1ps

module tmi_fifo #(
    parameter int W     = 7,
    parameter int DEPTH = 8
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    ready;
        logic                    valid;
    } tmi_fifo_st_t;

    localparam tmi_fifo_st_t ST_RST = '{
        mem:   '0,
        wp:    '0,
        rp:    '0,
        cnt:   '0,
        ready: 1'b1,
        valid: 1'b0
    };

    tmi_fifo_st_t st_r;
    tmi_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    always_comb begin
        push   = in_valid_i && st_r.ready;
        pop    = out_ready_i && st_r.valid;
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_i;
            st_nxt.wp = (st_r.wp == PTR_LAST) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == PTR_LAST) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + CNT_ONE;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - CNT_ONE;
        end
        st_nxt.ready = (st_nxt.cnt != CNT_FULL);
        st_nxt.valid = (st_nxt.cnt != '0);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready_o  = st_r.ready;
    assign out_valid_o = st_r.valid;
    assign out_data_o  = st_r.mem[st_r.rp];

endmodule // tmi_fifo

module tmi_interpreter #(
    parameter int DEPTH = tmi_pkg::FIFO_DEPTH
) (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         logic_reset_i,
    input  wire logic [tmi_pkg::CODE_W-1:0]   char_i,
    input  wire logic                         char_valid_i,
    output logic                              char_ready_o,
    output tmi_pkg::tmi_event_t               evt_o,
    output logic                              evt_valid_o,
    input  wire logic                         evt_ready_i,
    output tmi_pkg::tmi_mode_t                mode_o,
    output logic                              draw_ret_graphic_o
);
    typedef struct packed {
        logic                 lr_meta;
        logic                 lr_sync;
        tmi_pkg::tmi_mode_t   mode;
        tmi_pkg::tmi_mode_t   prev;
        logic                 draw_ret;
        logic                 evt_valid;
        tmi_pkg::tmi_event_t  evt;
    } tmi_state_t;

    localparam tmi_state_t ST_RST = '{
        lr_meta:   1'b0,
        lr_sync:   1'b0,
        mode:      tmi_pkg::MODE_ALPHA,
        prev:      tmi_pkg::MODE_ALPHA,
        draw_ret:  1'b0,
        evt_valid: 1'b0,
        evt:       '{kind:   tmi_pkg::KIND_TEXT,
                     code:   '0,
                     symbol: '0,
                     mode:   tmi_pkg::MODE_ALPHA}
    };

    tmi_state_t                  st_r;
    tmi_state_t                  st_nxt;
    logic [tmi_pkg::CODE_W-1:0]  code;
    logic                        code_valid;
    logic                        take;
    logic                        fifo_ready;
    logic                        is_ctrl;
    logic                        is_sym;

    tmi_fifo #(
        .W     (tmi_pkg::CODE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   (char_i),
        .in_valid_i  (char_valid_i),
        .in_ready_o  (fifo_ready),
        .out_data_o  (code),
        .out_valid_o (code_valid),
        .out_ready_i (take)
    );

    // the output stage stalls the buffer while its event is unread
    assign take = code_valid && !st_r.lr_sync
               && (!st_r.evt_valid || evt_ready_i);

    // column field sits above the row field
    assign is_ctrl = code[tmi_pkg::COL_HI:tmi_pkg::COL_LO]
                     <= tmi_pkg::COL_CTRL_MAX;
    assign is_sym  = (code >= tmi_pkg::SYM_FIRST)
                  && (code <= tmi_pkg::SYM_LAST);

    always_comb begin
        logic [tmi_pkg::CODE_W-1:0] sym_off;
        sym_off = code - tmi_pkg::SYM_FIRST;
        st_nxt = st_r;
        st_nxt.lr_meta = logic_reset_i;
        st_nxt.lr_sync = st_r.lr_meta;
        if (st_r.evt_valid && evt_ready_i) begin
            st_nxt.evt_valid = 1'b0;
        end
        if (st_r.lr_sync) begin
            st_nxt.mode     = tmi_pkg::MODE_ALPHA;
            st_nxt.prev     = tmi_pkg::MODE_ALPHA;
            st_nxt.draw_ret = 1'b0;
        end else if (take) begin
            st_nxt.evt.code   = code;
            st_nxt.evt.symbol = '0;
            unique case (st_r.mode)
                tmi_pkg::MODE_ALPHA,
                tmi_pkg::MODE_GRAPHIC,
                tmi_pkg::MODE_DRAW: begin
                    st_nxt.evt.mode = st_r.mode;
                    if (code == tmi_pkg::ESC_CODE) begin
                        // remember where to come back to
                        st_nxt.prev = st_r.mode;
                        st_nxt.mode = tmi_pkg::MODE_ESC;
                    end else if (is_ctrl) begin
                        // executed, permanent mode untouched
                        st_nxt.evt_valid = 1'b1;
                        st_nxt.evt.kind  = tmi_pkg::KIND_CTRL;
                    end else if (st_r.mode == tmi_pkg::MODE_DRAW) begin
                        st_nxt.evt_valid = 1'b1;
                        st_nxt.evt.kind  = tmi_pkg::KIND_GRAPH;
                    end else if (st_r.mode == tmi_pkg::MODE_GRAPHIC
                                 && is_sym) begin
                        st_nxt.evt_valid  = 1'b1;
                        st_nxt.evt.kind   = tmi_pkg::KIND_SYMBOL;
                        st_nxt.evt.symbol = sym_off[tmi_pkg::SYM_W-1:0];
                    end else begin
                        st_nxt.evt_valid = 1'b1;
                        st_nxt.evt.kind  = tmi_pkg::KIND_TEXT;
                    end
                end
                tmi_pkg::MODE_ESC: begin
                    // the one character after escape resolves it
                    st_nxt.mode     = st_r.prev;
                    st_nxt.evt.mode = st_r.prev;
                    if (st_r.prev == tmi_pkg::MODE_DRAW) begin
                        if (code == tmi_pkg::KEY_TWO) begin
                            st_nxt.mode = st_r.draw_ret
                                        ? tmi_pkg::MODE_GRAPHIC
                                        : tmi_pkg::MODE_ALPHA;
                        end else if (code == tmi_pkg::KEY_F) begin
                            st_nxt.draw_ret = 1'b1;
                        end else if (code == tmi_pkg::KEY_G) begin
                            st_nxt.draw_ret = 1'b0;
                        end else if (code != tmi_pkg::KEY_ONE) begin
                            st_nxt.evt_valid = 1'b1;
                            st_nxt.evt.kind  = tmi_pkg::KIND_ESCFN;
                        end
                    end else if (code == tmi_pkg::KEY_ONE) begin
                        st_nxt.mode     = tmi_pkg::MODE_DRAW;
                        st_nxt.draw_ret =
                            (st_r.prev == tmi_pkg::MODE_GRAPHIC);
                    end else if (code == tmi_pkg::KEY_F) begin
                        st_nxt.mode = tmi_pkg::MODE_GRAPHIC;
                    end else if (code == tmi_pkg::KEY_G) begin
                        st_nxt.mode = tmi_pkg::MODE_ALPHA;
                    end else if (code != tmi_pkg::KEY_TWO) begin
                        st_nxt.evt_valid = 1'b1;
                        st_nxt.evt.kind  = tmi_pkg::KIND_ESCFN;
                    end
                end
                default: begin
                    st_nxt.mode = tmi_pkg::MODE_ALPHA;
                    st_nxt.prev = tmi_pkg::MODE_ALPHA;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign char_ready_o       = fifo_ready;
    assign evt_o              = st_r.evt;
    assign evt_valid_o        = st_r.evt_valid;
    assign mode_o             = st_r.mode;
    assign draw_ret_graphic_o = st_r.draw_ret;

    // symbol index as the assertions expect it
    logic [tmi_pkg::CODE_W-1:0] sym_full;
    logic [tmi_pkg::SYM_W-1:0]  sym_idx;
    assign sym_full = code - tmi_pkg::SYM_FIRST;
    assign sym_idx  = sym_full[tmi_pkg::SYM_W-1:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_esc_take(logic [tmi_pkg::CODE_W-1:0] k);
        take && st_r.mode == tmi_pkg::MODE_ESC && code == k;
    endsequence

    sequence s_perm_take;
        take && st_r.mode != tmi_pkg::MODE_ESC;
    endsequence

    AST_ALPHA_F: assert property (
        s_esc_take(tmi_pkg::KEY_F) and
        (st_r.prev == tmi_pkg::MODE_ALPHA)
        |=> st_r.mode == tmi_pkg::MODE_GRAPHIC)
        else $error("escape F from alphanumeric missed graphic");

    AST_GRAPHIC_G: assert property (
        s_esc_take(tmi_pkg::KEY_G) and
        (st_r.prev == tmi_pkg::MODE_GRAPHIC)
        |=> st_r.mode == tmi_pkg::MODE_ALPHA)
        else $error("escape G from graphic missed alphanumeric");

    AST_ONE_DRAW: assert property (
        s_esc_take(tmi_pkg::KEY_ONE) and
        (st_r.prev != tmi_pkg::MODE_DRAW)
        |=> st_r.mode == tmi_pkg::MODE_DRAW
            && st_r.draw_ret == $past(st_r.prev == tmi_pkg::MODE_GRAPHIC))
        else $error("escape 1 did not enter drawing correctly");

    AST_TWO_RETURN: assert property (
        s_esc_take(tmi_pkg::KEY_TWO) and
        (st_r.prev == tmi_pkg::MODE_DRAW)
        |=> st_r.mode == ($past(st_r.draw_ret) ? tmi_pkg::MODE_GRAPHIC
                                               : tmi_pkg::MODE_ALPHA))
        else $error("escape 2 returned to wrong mode");

    AST_DRAW_FG: assert property (
        take && st_r.mode == tmi_pkg::MODE_ESC
        && st_r.prev == tmi_pkg::MODE_DRAW
        && (code == tmi_pkg::KEY_F || code == tmi_pkg::KEY_G)
        |=> st_r.mode == tmi_pkg::MODE_DRAW
            && st_r.draw_ret == $past(code == tmi_pkg::KEY_F))
        else $error("escape F or G in drawing mishandled");

    AST_CTRL_KEEPS: assert property (
        s_perm_take and (is_ctrl && code != tmi_pkg::ESC_CODE)
        |=> $stable(st_r.mode) && st_r.evt_valid
            && st_r.evt.kind == tmi_pkg::KIND_CTRL)
        else $error("control code changed mode or was dropped");

    AST_ESC_ROUND: assert property (
        s_perm_take and (code == tmi_pkg::ESC_CODE)
        |=> st_r.mode == tmi_pkg::MODE_ESC
            && st_r.prev == $past(st_r.mode))
        else $error("escape did not enter escape mode");

    AST_ESC_ONE_CHAR: assert property (
        take && st_r.mode == tmi_pkg::MODE_ESC
        |=> st_r.mode != tmi_pkg::MODE_ESC)
        else $error("escape mode outlived one character");

    AST_SYMBOL: assert property (
        s_perm_take and (st_r.mode == tmi_pkg::MODE_GRAPHIC && is_sym)
        |=> st_r.evt_valid && st_r.evt.kind == tmi_pkg::KIND_SYMBOL
            && st_r.evt.symbol == $past(sym_idx))
        else $error("graphic symbol not selected");

    AST_GRAPH: assert property (
        s_perm_take and (st_r.mode == tmi_pkg::MODE_DRAW && !is_ctrl)
        |=> st_r.evt_valid && st_r.evt.kind == tmi_pkg::KIND_GRAPH)
        else $error("printable in drawing not routed as graph data");

    AST_RESET_ALPHA: assert property (
        st_r.lr_sync ##1 st_r.lr_sync
        |-> st_r.mode == tmi_pkg::MODE_ALPHA && !st_r.draw_ret)
        else $error("logic reset did not force alphanumeric");

endmodule // tmi_interpreter

// ==== tmi_host.sv ====
// host model that offers characters over the valid and ready handshake
`timescale 1ns/1ps

module tmi_host (
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    output logic [6:0]      char_o,
    output logic            valid_o
);
    logic [6:0] char_q [$];
    int         gap_q  [$];
    int         wait_n;
    logic       rdy_q;
    logic       done;

    initial begin
        valid_o = 1'b0;
        char_o  = 7'h00;
        wait_n  = 0;
        rdy_q   = 1'b0;
        done    = 1'b0;
    end

    // ready is registered, so its level at the falling edge is the one
    // sampled at the next rising edge
    // valid stays up between back-to-back characters, char_o and valid_o are
    // assigned at most once per falling edge
    always @(negedge clk_i) begin
        done = (valid_o === 1'b1 && rdy_q === 1'b1);
        if (done) begin
            wait_n = gap_q.pop_front();
        end
        if (done || valid_o !== 1'b1) begin
            if (wait_n == 0 && char_q.size() > 0) begin
                char_o  = char_q.pop_front();
                valid_o = 1'b1;
            end else begin
                // released line keeps changing so stale data never matches
                char_o  = ~char_o;
                valid_o = 1'b0;
                if (wait_n > 0) begin
                    wait_n--;
                end
            end
        end
        rdy_q = ready_i;
    end

    task automatic send(input logic [6:0] c, input int gap);
        char_q.push_back(c);
        gap_q.push_back(gap);
    endtask

    function automatic logic busy();
        return char_q.size() > 0 || valid_o === 1'b1;
    endfunction
endmodule // tmi_host

// ==== terminal_mode_interpreter_test.sv ====
// self-checking testbench of the terminal mode interpreter
`timescale 1ns/1ps

module terminal_mode_interpreter_test;
    logic                    clk_i = 1'b0;
    logic                    reset_i = 1'b1;
    logic                    logic_reset_i = 1'b0;
    logic [6:0]              char_i;
    logic                    char_valid_i;
    logic                    char_ready_o;
    tmi_pkg::tmi_event_t     evt_o;
    logic                    evt_valid_o;
    logic                    evt_ready_i = 1'b1;
    tmi_pkg::tmi_mode_t      mode_o;
    logic                    draw_ret_graphic_o;
    int                      fail_count = 0;
    int                      samples_checked = 0;
    int                      seed = 32'h851d;
    int                      rmode = 0;
    tmi_pkg::tmi_event_t     exp_q [$];
    tmi_pkg::tmi_event_t     got_e;
    tmi_pkg::tmi_mode_t      perm = tmi_pkg::MODE_ALPHA;
    logic                    in_esc = 1'b0;
    logic                    dret = 1'b0;
    logic [6:0]              dir [] = '{7'h41, 7'h00, 7'h1f, 7'h20,
        7'h1b, 7'h46, 7'h61, 7'h7e, 7'h60, 7'h7f, 7'h0a, 7'h1b, 7'h5a,
        7'h1b, 7'h47, 7'h1b, 7'h47, 7'h1b, 7'h46, 7'h1b, 7'h31, 7'h41,
        7'h7f, 7'h0a, 7'h1b, 7'h47, 7'h1b, 7'h5a, 7'h1b, 7'h31, 7'h1b,
        7'h46, 7'h1b, 7'h47, 7'h1b, 7'h32, 7'h1b, 7'h32, 7'h1b, 7'h1b,
        7'h1b, 7'h31, 7'h1b, 7'h32};

    always #5 clk_i = ~clk_i;

    tmi_host host_u (
        .clk_i   (clk_i),
        .ready_i (char_ready_o),
        .char_o  (char_i),
        .valid_o (char_valid_i)
    );

    tmi_interpreter #(.DEPTH(tmi_pkg::FIFO_DEPTH)) dut_u (
        .clk_i              (clk_i),
        .reset_i            (reset_i),
        .logic_reset_i      (logic_reset_i),
        .char_i             (char_i),
        .char_valid_i       (char_valid_i),
        .char_ready_o       (char_ready_o),
        .evt_o              (evt_o),
        .evt_valid_o        (evt_valid_o),
        .evt_ready_i        (evt_ready_i),
        .mode_o             (mode_o),
        .draw_ret_graphic_o (draw_ret_graphic_o)
    );

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // reference interpreter: queues the event each character should give
    task automatic predict(input logic [6:0] c);
        tmi_pkg::tmi_event_t e;
        logic                hit;
        e = '0;
        e.code = c;
        e.mode = perm;
        hit = 1'b1;
        if (in_esc) begin
            in_esc = 1'b0;
            e.kind = tmi_pkg::KIND_ESCFN;
            if (c == tmi_pkg::KEY_F || c == tmi_pkg::KEY_G) begin
                hit = 1'b0;
                if (perm == tmi_pkg::MODE_DRAW)
                    dret = (c == tmi_pkg::KEY_F);
                else if (c == tmi_pkg::KEY_F && perm == tmi_pkg::MODE_ALPHA)
                    perm = tmi_pkg::MODE_GRAPHIC;
                else if (c == tmi_pkg::KEY_G && perm != tmi_pkg::MODE_ALPHA)
                    perm = tmi_pkg::MODE_ALPHA;
            end else if (c == tmi_pkg::KEY_ONE) begin
                hit = 1'b0;
                if (perm != tmi_pkg::MODE_DRAW) begin
                    dret = (perm == tmi_pkg::MODE_GRAPHIC);
                    perm = tmi_pkg::MODE_DRAW;
                end
            end else if (c == tmi_pkg::KEY_TWO) begin
                hit = 1'b0;
                if (perm == tmi_pkg::MODE_DRAW)
                    perm = dret ? tmi_pkg::MODE_GRAPHIC : tmi_pkg::MODE_ALPHA;
            end
        end else if (c == tmi_pkg::ESC_CODE) begin
            in_esc = 1'b1;
            hit = 1'b0;
        end else if (c[6:4] <= tmi_pkg::COL_CTRL_MAX)
            e.kind = tmi_pkg::KIND_CTRL;
        else if (perm == tmi_pkg::MODE_DRAW)
            e.kind = tmi_pkg::KIND_GRAPH;
        else if (perm == tmi_pkg::MODE_GRAPHIC && c >= tmi_pkg::SYM_FIRST
                 && c <= tmi_pkg::SYM_LAST) begin
            e.kind = tmi_pkg::KIND_SYMBOL;
            e.symbol = 5'(c - tmi_pkg::SYM_FIRST);
        end else
            e.kind = tmi_pkg::KIND_TEXT;
        if (hit) exp_q.push_back(e);
    endtask

    task automatic put(input logic [6:0] c, input int gap);
        predict(c);
        host_u.send(c, gap);
    endtask

    function automatic logic [6:0] pick();
        int r;
        r = $random(seed) & 15;
        case (r)
            0, 1: return tmi_pkg::ESC_CODE;
            2: return tmi_pkg::KEY_F;
            3: return tmi_pkg::KEY_G;
            4: return tmi_pkg::KEY_ONE;
            5: return tmi_pkg::KEY_TWO;
            default: return 7'($random(seed));
        endcase
    endfunction

    task automatic settle();
        int n;
        n = 0;
        while ((exp_q.size() > 0 || host_u.busy()) && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        repeat (4) @(negedge clk_i);
        check("events left", 0, exp_q.size());
        check("mode", in_esc ? tmi_pkg::MODE_ESC : perm, mode_o);
        check("draw return", dret, draw_ret_graphic_o);
    endtask

    always @(negedge clk_i)
        evt_ready_i <= (rmode == 0) || (rmode == 1 && ($random(seed) & 1));

    always @(posedge clk_i) begin
        if (!reset_i && evt_valid_o === 1'b1 && evt_ready_i === 1'b1) begin
            got_e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
            check("event kind", got_e.kind, evt_o.kind);
            check("event code", got_e.code, evt_o.code);
            check("event mode", got_e.mode, evt_o.mode);
            if (got_e.kind == tmi_pkg::KIND_SYMBOL)
                check("symbol", got_e.symbol, evt_o.symbol);
        end
    end

    initial begin
        #200_000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        check("ready after reset", 1, char_ready_o);
        check("valid after reset", 0, evt_valid_o);
        check("mode after reset", tmi_pkg::MODE_ALPHA, mode_o);
        check("return after reset", 0, draw_ret_graphic_o);
        $display("test reset done");
        foreach (dir[i]) put(dir[i], 0);
        settle();
        $display("test directed done");
        rmode = 1;
        for (int i = 0; i < 600; i++) begin
            put(pick(), $random(seed) & 3);
            if (i % 100 == 99) settle();
        end
        $display("test random done");
        rmode = 2;
        for (int i = 0; i <= tmi_pkg::FIFO_DEPTH; i++) put(7'(8'h41 + i), 0);
        for (int n = 0; n < 100 && host_u.busy(); n++) @(negedge clk_i);
        repeat (3) @(negedge clk_i);
        check("ready when full", 0, char_ready_o);
        rmode = 0;
        settle();
        check("ready when empty", 1, char_ready_o);
        $display("test buffer done");
        foreach (dir[i]) if (i < 7) put(7'h1b, 0);
        put(7'h32, 0);
        put(7'h1b, 0);
        put(7'h47, 0);
        put(7'h1b, 0);
        put(7'h46, 0);
        put(7'h1b, 0);
        put(7'h31, 0);
        put(7'h1b, 0);
        settle();
        logic_reset_i = 1'b1;
        repeat (5) @(negedge clk_i);
        check("mode in logic reset", tmi_pkg::MODE_ALPHA, mode_o);
        check("return in logic reset", 0, draw_ret_graphic_o);
        logic_reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        perm = tmi_pkg::MODE_ALPHA;
        in_esc = 1'b0;
        dret = 1'b0;
        put(7'h62, 0);
        settle();
        $display("test logic reset done");
        tally_and_finish();
    end
endmodule // terminal_mode_interpreter_test
